// ==== inc/afe_defs.svh ====
// Constants for the two-wire configuration port: addresses, offsets, timing
`ifndef AFE_DEFS_SVH
`define AFE_DEFS_SVH

// Device bus address and direction bit
`define DEV_ADDR          7'h4C
`define DIR_READ          1'b1

// Register offsets
`define REG_SYNC_SEL      8'h01
`define REG_SYNC_ACT      8'h02
`define REG_POWER_DOWN    8'h2C

// Field values
`define STANDBY_CODE      8'h0F
`define REG_DEFAULT       8'h00
`define REG_COUNT         256

// Clock rates and crystal reference divider
`define SYS_HZ            100000000
`define XTAL_HZ           25000000
`define XTAL_DIV          (`SYS_HZ / `XTAL_HZ)

// Deglitch delay in reference periods, and its nominal time
`define DEGLITCH_TICKS    3
`define DEGLITCH_NS       120

// Power-on reset length in reference periods
`define POR_XTAL_CYCLES   524288

`endif

// ==== inc/afe_pkg.sv ====
// Types shared by the two-wire configuration port
`default_nettype none
package afe_pkg;

  // Serial slave states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b000_0001,
    ST_ADDR     = 7'b000_0010,
    ST_ADDR_ACK = 7'b000_0100,
    ST_WR_BYTE  = 7'b000_1000,
    ST_WR_ACK   = 7'b001_0000,
    ST_RD_BYTE  = 7'b010_0000,
    ST_RD_ACK   = 7'b100_0000
  } port_state_t;

  // Register data and address types
  typedef logic [7:0] reg_byte_t;

endpackage
`default_nettype wire

// ==== hdl/line_deglitch.sv ====
// Reference-clocked deglitch filter for one serial bus line
`default_nettype none
`include "afe_defs.svh"
module line_deglitch (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Reference tick and synchronised line
  input  wire logic xtal_tick,
  input  wire logic line_sync,
  // Filtered line
  output logic      line_clean
);
  localparam int TICKS = `DEGLITCH_TICKS;

  logic [1:0] agree_cnt;  // Ticks the new level has held

  // Follow the line only after it holds a new level for three ticks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      agree_cnt  <= 2'h0;
      line_clean <= 1'b1;  // Idle bus is high
    end else if (xtal_tick) begin
      if (line_sync == line_clean) begin
        agree_cnt <= 2'h0;  // Short pulse dropped
      end else if (agree_cnt == 2'(TICKS - 1)) begin
        agree_cnt  <= 2'h0;
        line_clean <= line_sync;
      end else begin
        agree_cnt <= agree_cnt + 2'h1;
      end
    end
  end
endmodule // line_deglitch
`default_nettype wire

// ==== hdl/config_reg_file.sv ====
// Configuration register array with read-only status words
`default_nettype none
`include "afe_defs.svh"
module config_reg_file
  import afe_pkg::*;
(
  // Clock and register reset
  input  wire logic      sys_clk,
  input  wire logic      clear,
  // Write port
  input  wire logic      wr_en,
  input  wire reg_byte_t wr_addr,
  input  wire reg_byte_t wr_data,
  // Read port
  input  wire reg_byte_t rd_addr,
  output reg_byte_t      rd_data,
  // Status sources
  input  wire reg_byte_t sel_sync_status,
  input  wire reg_byte_t sync_activity,
  // Standby control value
  output reg_byte_t      power_down_control
);
  reg_byte_t mem [`REG_COUNT];  // Register storage

  // Status words are never stored, so a write cannot hide them
  function automatic logic is_status(input reg_byte_t a);
    is_status = (a == `REG_SYNC_SEL) || (a == `REG_SYNC_ACT);
  endfunction

  // Defaults on reset (all zero: first graphics input, RGB, AC coupled); writes
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        mem[i] <= `REG_DEFAULT;
      end
    end else if (wr_en && !is_status(wr_addr)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read mux; status sources stay live in standby
  always_comb begin
    if (rd_addr == `REG_SYNC_SEL) begin
      rd_data = sel_sync_status;
    end else if (rd_addr == `REG_SYNC_ACT) begin
      rd_data = sync_activity;
    end else begin
      rd_data = mem[rd_addr];
    end
  end

  assign power_down_control = mem[`REG_POWER_DOWN];
endmodule // config_reg_file
`default_nettype wire

// ==== hdl/afe_two_wire_config_port.sv ====
// Two-wire configuration port, register file, reset and standby control
`default_nettype none
`include "afe_defs.svh"
module afe_two_wire_config_port
  import afe_pkg::*;
#(
  parameter int POR_TICKS = `POR_XTAL_CYCLES  // Reference ticks of power-on reset
) (
  // System clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Serial bus pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // External reset pin
  input  wire logic               reset_pin_n,
  // Sync status sources
  input  wire afe_pkg::reg_byte_t sel_sync_status,
  input  wire afe_pkg::reg_byte_t sync_activity,
  // Sync buffers
  input  wire logic               line_sync_in,
  input  wire logic               frame_sync_in,
  output logic                    buffered_line_sync_out,
  output logic                    buffered_frame_sync_out,
  // Power state
  output logic                    standby,
  output afe_pkg::reg_byte_t      power_down_control,
  output logic                    por_busy
);
  import afe_pkg::*;

  localparam int XTAL_DIV = `XTAL_DIV;

  // Pin synchroniser order: scl, sda, reset pin
  localparam int NPIN = 3;

  logic [NPIN-1:0] pin_raw;     // Raw pin levels
  logic [NPIN-1:0] pin_meta;    // First synchroniser stage
  logic [NPIN-1:0] pin_sync;    // Second synchroniser stage
  logic [1:0]      div_cnt;     // Reference divider
  logic            xtal_tick;   // One pulse per reference period
  logic [19:0]     por_cnt;     // Power-on reset tick count
  logic            scl_f;       // Deglitched clock line
  logic            sda_f;       // Deglitched data line
  logic            scl_q;       // Previous deglitched clock
  logic            sda_q;       // Previous deglitched data
  logic            scl_rise;    // Delayed rising edge
  logic            scl_fall;    // Delayed falling edge
  logic            start_det;   // Start or repeated start
  logic            stop_det;    // Stop
  port_state_t     state;       // Slave state
  logic [3:0]      bit_cnt;     // Bits moved in current byte
  reg_byte_t       shift;       // Byte shifter
  reg_byte_t       ptr;         // Register pointer
  logic            ptr_loaded;  // Pointer byte already taken
  logic            host_ack;    // Host acknowledged last read byte
  logic            drive_low;   // Pull data line low
  logic            wr_en;       // One-cycle register write
  reg_byte_t       wr_data;     // Byte to store
  reg_byte_t       rd_data;     // Byte at pointer

  // Eight bits complete a byte
  function automatic logic byte_done(input logic [3:0] cnt);
    byte_done = (cnt == 4'h8);
  endfunction

  assign pin_raw = {reset_pin_n, sda_in, scl_in};

  // Two flip-flops per pin before any logic looks at it
  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_meta[g] <= 1'b1;  // Idle high
          pin_sync[g] <= 1'b1;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  // Reference clock enable from the system clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt <= 2'h0;
    end else if (div_cnt == 2'(XTAL_DIV - 1)) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  assign xtal_tick = (div_cnt == 2'(XTAL_DIV - 1));

  // Power-on reset; the pin restarts the same sequence
  always_ff @(posedge sys_clk) begin
    if (rst || !pin_sync[2]) begin
      por_busy <= 1'b1;
      por_cnt  <= 20'h0_0000;
    end else if (por_busy && xtal_tick) begin
      if (por_cnt == 20'(POR_TICKS - 1)) begin
        por_busy <= 1'b0;
      end else begin
        por_cnt <= por_cnt + 20'h0_0001;
      end
    end
  end

  // Clock and data through matching filters so start and stop keep their order
  line_deglitch u_scl_filter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .xtal_tick  (xtal_tick),
    .line_sync  (pin_sync[0]),
    .line_clean (scl_f)
  );

  line_deglitch u_sda_filter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .xtal_tick  (xtal_tick),
    .line_sync  (pin_sync[1]),
    .line_clean (sda_f)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Edges and bus conditions on the delayed lines
  assign scl_rise  = scl_f && !scl_q;
  assign scl_fall  = !scl_f && scl_q;
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det  = scl_f && scl_q && !sda_q && sda_f;

  // Slave sequencer: address, pointer, data, acknowledge
  always_ff @(posedge sys_clk) begin
    if (rst || por_busy) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      ptr        <= 8'h00;
      ptr_loaded <= 1'b0;
      host_ack   <= 1'b0;
      drive_low  <= 1'b0;
      wr_en      <= 1'b0;
      wr_data    <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_det) begin
        // Start, also mid-transfer: direction ends, address follows
        state     <= ST_ADDR;
        bit_cnt   <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_det) begin
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            // Nothing happens here but waiting for a start
            drive_low <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise && !byte_done(bit_cnt)) begin
              shift   <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done(bit_cnt)) begin
              if (shift[7:1] == `DEV_ADDR) begin
                drive_low <= 1'b1;
                state     <= ST_ADDR_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (shift[0] == `DIR_READ) begin
                // First read byte comes from the current pointer
                shift     <= rd_data;
                ptr       <= ptr + 8'h01;
                drive_low <= !rd_data[7];
                state     <= ST_RD_BYTE;
              end else begin
                ptr_loaded <= 1'b0;
                drive_low  <= 1'b0;
                state      <= ST_WR_BYTE;
              end
            end
          end
          ST_WR_BYTE: begin
            if (scl_rise && !byte_done(bit_cnt)) begin
              shift   <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done(bit_cnt)) begin
              if (!ptr_loaded) begin
                ptr        <= shift;
                ptr_loaded <= 1'b1;
              end else begin
                wr_en   <= 1'b1;
                wr_data <= shift;
              end
              drive_low <= 1'b1;
              state     <= ST_WR_ACK;
            end
          end
          ST_WR_ACK: begin
            // Pointer steps once the stored byte has gone in
            if (scl_fall) begin
              drive_low <= 1'b0;
              bit_cnt   <= 4'h0;
              state     <= ST_WR_BYTE;
            end
            if (wr_en) begin
              ptr <= ptr + 8'h01;
            end
          end
          ST_RD_BYTE: begin
            // Data moves only after the delayed falling edge
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                drive_low <= 1'b0;
                state     <= ST_RD_ACK;
              end else begin
                shift     <= {shift[6:0], 1'b0};
                drive_low <= !shift[6];
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              host_ack <= !sda_f;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (host_ack) begin
                shift     <= rd_data;
                ptr       <= ptr + 8'h01;
                drive_low <= !rd_data[7];
                state     <= ST_RD_BYTE;
              end else begin
                // No acknowledge: release and wait for stop or start
                drive_low <= 1'b0;
                state     <= ST_IDLE;
              end
            end
          end
          default: begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // Storage; the port keeps working in standby
  config_reg_file u_regs (
    .sys_clk            (sys_clk),
    .clear              (por_busy),
    .wr_en              (wr_en),
    .wr_addr            (ptr),
    .wr_data            (wr_data),
    .rd_addr            (ptr),
    .rd_data            (rd_data),
    .sel_sync_status    (sel_sync_status),
    .sync_activity      (sync_activity),
    .power_down_control (power_down_control)
  );

  // Open drain: only ever pulls low, otherwise released
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  // Standby flag from the power-down code
  always_ff @(posedge sys_clk) begin
    if (rst || por_busy) begin
      standby <= 1'b0;
    end else begin
      standby <= (power_down_control == `STANDBY_CODE);
    end
  end

  // Unsynchronised buffers so mode detection sees true widths, even in standby
  assign buffered_line_sync_out  = line_sync_in;
  assign buffered_frame_sync_out = frame_sync_in;

endmodule // afe_two_wire_config_port
`default_nettype wire

// ==== tb/afe_port_sva.sv ====
// Pin-level checker for the two-wire configuration port
`default_nettype none
module afe_port_checker
  import afe_pkg::*;
#(
  parameter int POR_TICKS = 8  // Reference ticks of power-on reset
) (
  // Clock and reset
  input wire logic      sys_clk,
  input wire logic      rst,
  // Bus and reset pins
  input wire logic      scl_in,
  input wire logic      sda_out,
  input wire logic      sda_oe,
  input wire logic      reset_pin_n,
  // Sync buffers
  input wire logic      line_sync_in,
  input wire logic      frame_sync_in,
  input wire logic      buffered_line_sync_out,
  input wire logic      buffered_frame_sync_out,
  // Power state
  input wire logic      standby,
  input wire reg_byte_t power_down_control,
  input wire logic      por_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int low_cnt;  // Cycles the clock pin has been low
  int por_cnt;  // Cycles of the running power-on sequence
  // Low phase length, saturating so it never wraps
  always_ff @(posedge sys_clk) begin
    if (scl_in) low_cnt <= 0;
    else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
  end
  // Busy length, restarted by either reset source
  always_ff @(posedge sys_clk) begin
    if (rst || !reset_pin_n || !por_busy) por_cnt <= 0;
    else por_cnt <= por_cnt + 1;
  end
  sequence s_reset_release;
    $fell(rst);
  endsequence
  sequence s_por_end;
    $fell(por_busy);
  endsequence
  a_od_value: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_line_buf: assert property (buffered_line_sync_out == line_sync_in)
    else $error("line sync buffer wrong");
  a_frame_buf: assert property (buffered_frame_sync_out == frame_sync_in)
    else $error("frame sync buffer wrong");
  a_standby_enter: assert property (power_down_control == 8'h0F && !por_busy |=> standby)
    else $error("standby not entered");
  a_standby_exit: assert property (power_down_control != 8'h0F |=> !standby)
    else $error("standby without code");
  a_reset_quiet: assert property (por_busy |-> !sda_oe && !standby)
    else $error("active during power-on");
  a_reset_defaults: assert property (por_busy && $past(por_busy, 2) |-> power_down_control == 8'h00)
    else $error("register not at default");
  a_por_start: assert property (s_reset_release |-> por_busy)
    else $error("power-on not started");
  a_por_length: assert property (s_por_end |-> por_cnt >= 4 * POR_TICKS - 4 && por_cnt <= 4 * POR_TICKS + 8)
    else $error("power-on length wrong");
  a_drive_after_fall: assert property ($changed(sda_oe) |-> low_cnt >= 8)
    else $error("data moved outside clock low");
endmodule  // afe_port_checker
bind afe_two_wire_config_port afe_port_checker #(.POR_TICKS(POR_TICKS)) chk_u (
  .sys_clk, .rst, .scl_in, .sda_out, .sda_oe, .reset_pin_n, .line_sync_in, .frame_sync_in,
  .buffered_line_sync_out, .buffered_frame_sync_out, .standby, .power_down_control, .por_busy
);
`default_nettype wire

// ==== tb/two_wire_host_model.sv ====
// Behavioural two-wire bus master for the configuration port
`default_nettype none
module two_wire_host_model #(
  parameter int HALF = 30  // System cycles per clock phase
) (
  // Pacing clock and resolved data line
  input  wire logic sys_clk,
  input  wire logic sda,
  // Serial clock and data pull-down
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles with both lines high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One phase; lines move just after an edge
  task automatic hold();
    repeat (HALF) @(posedge sys_clk);
    #1;
  endtask
  // Start, also used as repeated start
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  // Data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      hold();
      scl = 1'b1;
      hold();
      rx[i] = sda;
      scl = 1'b0;
      hold();
    end
    q = rx[8:1];
    ack = rx[0];
  endtask
  // Short clock spike that the port must not count
  task automatic glitch();
    scl = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    scl = 1'b0;
    hold();
  endtask
endmodule  // two_wire_host_model
`default_nettype wire

// ==== tb/afe_two_wire_config_port_tb_top.sv ====
// Self-checking bench for the two-wire configuration port
`default_nettype none
`include "afe_defs.svh"
module afe_two_wire_config_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import afe_pkg::*;
  localparam int POR_T = 8;  // Shortened power-on count
  logic      sys_clk, rst, scl, sda_low, sda, sda_out, sda_oe, reset_pin_n;
  logic      line_sync_in, frame_sync_in, standby, por_busy;
  reg_byte_t sel_sync_status, sync_activity, power_down_control;
  reg_byte_t mirror [256];  // Expected register contents
  int        fails, checks;
  // Open-drain data line with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));
  afe_two_wire_config_port #(.POR_TICKS(POR_T)) dut_u (
    .sys_clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .reset_pin_n,
    .sel_sync_status, .sync_activity, .line_sync_in, .frame_sync_in,
    .buffered_line_sync_out(), .buffered_frame_sync_out(), .standby,
    .power_down_control, .por_busy);
  two_wire_host_model host_u (.sys_clk, .sda, .scl, .sda_low);
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Status words are live, the rest come from the mirror
  function automatic reg_byte_t expv(input reg_byte_t a);
    return a == `REG_SYNC_SEL ? sel_sync_status : a == `REG_SYNC_ACT ? sync_activity : mirror[a];
  endfunction
  // Bounded wait for the power-on sequence
  task automatic wait_por();
    for (int k = 0; k < 400 && por_busy !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (por_busy !== 1'b0) begin
      fails++;
      conclude();
    end
  endtask
  task automatic open_dev(input logic dir);
    reg_byte_t q;
    logic      a;
    host_u.start();
    host_u.xfer({`DEV_ADDR, dir}, 1'b1, q, a);
    check({7'h00, a}, 8'h00);
  endtask
  // Burst write of n counting bytes, optional spike before each
  task automatic wr(input reg_byte_t ptr, input reg_byte_t d, input int n, input logic g);
    reg_byte_t q;
    logic      a;
    open_dev(1'b0);
    host_u.xfer(ptr, 1'b1, q, a);
    check({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      if (g) host_u.glitch();
      host_u.xfer(d, 1'b1, q, a);
      check({7'h00, a}, 8'h00);
      if (ptr != `REG_SYNC_SEL && ptr != `REG_SYNC_ACT) mirror[ptr] = d;
      ptr++;
      d++;
    end
    host_u.stop();
  endtask
  // Pointer write, turnaround, n reads, last one refused
  task automatic rd(input reg_byte_t ptr, input int n);
    reg_byte_t q;
    logic      a;
    open_dev(1'b0);
    host_u.xfer(ptr, 1'b1, q, a);
    open_dev(1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'hFF, i == n - 1, q, a);
      check(q, expv(ptr));
      ptr++;
    end
    host_u.stop();
  endtask
  initial begin
    reg_byte_t q;
    logic      a;
    rst = 1'b1;
    reset_pin_n = 1'b1;
    {line_sync_in, frame_sync_in} = 2'b00;
    sel_sync_status = 8'h5A;
    sync_activity = 8'hC3;
    fails = 0;
    checks = 0;
    foreach (mirror[i]) mirror[i] = `REG_DEFAULT;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check({7'h00, por_busy}, 8'h01);
    wait_por();
    // Address without a start, then a foreign address
    host_u.xfer({`DEV_ADDR, 1'b0}, 1'b1, q, a);
    check({7'h00, a}, 8'h01);
    host_u.start();
    host_u.xfer({7'h4D, 1'b0}, 1'b1, q, a);
    check({7'h00, a}, 8'h01);
    host_u.stop();
    wr(8'h01, 8'h33, 2, 1'b0);
    wr(8'h10, 8'hA5, 4, 1'b0);
    wr(8'h20, 8'h77, 2, 1'b1);
    wr(8'hFF, 8'h3C, 2, 1'b0);
    rd(8'h00, 28);
    rd(8'h1F, 3);
    rd(8'hFF, 1);
    wr(`REG_POWER_DOWN, `STANDBY_CODE, 1, 1'b0);
    check({7'h00, standby}, 8'h01);
    check(power_down_control, `STANDBY_CODE);
    sel_sync_status = 8'hA6;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1;
      {line_sync_in, frame_sync_in} = i[1:0];
    end
    rd(8'h00, 3);
    rd(`REG_POWER_DOWN, 1);
    wr(`REG_POWER_DOWN, 8'h0E, 1, 1'b0);
    check({7'h00, standby}, 8'h00);
    reset_pin_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    reset_pin_n = 1'b1;
    foreach (mirror[i]) mirror[i] = `REG_DEFAULT;
    check({7'h00, por_busy}, 8'h01);
    wait_por();
    check(power_down_control, `REG_DEFAULT);
    rd(8'h10, 2);
    conclude();
  end
endmodule  // afe_two_wire_config_port_tb_top
`default_nettype wire
